// File: inc/psfb_pkg.sv
// psfb_pkg: command codes, page codes, field positions and masks
// of the latched status flag bank.
// assumes: one clock domain, all sources on that clock.
package psfb_pkg;

	// ************************************************************
	// command codes of the status bytes
	// ************************************************************
	localparam logic [7:0] CMD_INPUT  = 8'h7c; // shared input byte
	localparam logic [7:0] CMD_TEMP   = 8'h7d; // paged temperature byte
	localparam logic [7:0] CMD_COMM   = 8'h7e; // shared comm/logic/memory byte
	localparam logic [7:0] CMD_VENDOR = 8'h80; // paged vendor byte

	// ************************************************************
	// page selector codes
	// ************************************************************
	localparam logic [7:0] PAGE_A   = 8'h00; // channel a
	localparam logic [7:0] PAGE_B   = 8'h01; // channel b
	localparam logic [7:0] PAGE_ALL = 8'hff; // all channels

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int IN_OVF_BIT  = 7; // input over-voltage fault
	localparam int IN_UVF_BIT  = 4; // input under-voltage fault
	localparam int IN_LOW_BIT  = 3; // unit off for low input
	localparam int IN_OCF_BIT  = 2; // input over-current fault
	localparam int IN_OCW_BIT  = 1; // input over-current warning
	localparam int IN_OPW_BIT  = 0; // input over-power warning
	localparam int TMP_FLT_BIT = 7; // over-temperature fault
	localparam int TMP_WRN_BIT = 6; // over-temperature warning
	localparam int CM_CMD_BIT  = 7; // bad command code
	localparam int CM_DATA_BIT = 6; // bad payload
	localparam int CM_PEC_BIT  = 5; // packet check failed
	localparam int CM_MEM_BIT  = 3; // memory / nvm error
	localparam int CM_OTH_BIT  = 1; // other link fault

	// ************************************************************
	// supported bit masks and reset value
	// ************************************************************
	localparam logic [7:0] INPUT_MASK = 8'h9f; // bits 6,5 read zero
	localparam logic [7:0] TEMP_MASK  = 8'hc0; // bits 5..0 read zero
	localparam logic [7:0] COMM_MASK  = 8'hea; // bits 4,2,0 read zero
	localparam logic [7:0] VEND_MASK  = 8'hff; // default vendor layout
	localparam logic [7:0] FLAG_RESET = 8'h00; // flags after reset
	localparam logic [7:0] READ_NONE  = 8'h00; // answer for no match

	// ************************************************************
	// channel selection decoded from the page selector
	// ************************************************************
	typedef enum logic [1:0]
	{
		PSFB_CHAN_NONE = 2'b00,
		PSFB_CHAN_A    = 2'b01,
		PSFB_CHAN_B    = 2'b10,
		PSFB_CHAN_ALL  = 2'b11
	} psfb_chan_type;

endpackage

// File: logic/psfb_flag_byte.sv
// psfb_flag_byte: one byte of latched, write-one-to-clear flags.
// assumes: set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module psfb_flag_byte
#(
	parameter logic [7:0] SUPPORTED = 8'hff
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] set_bits,
	input  wire logic [7:0] clear_bits,
	output var  logic [7:0] flags
);
	import psfb_pkg::*;

	// ************************************************************
	// next value: set beats clear, unsupported bits forced low
	// ************************************************************
	wire logic [7:0] next_flags; // value for the next edge

	// a condition still present on a clear keeps its flag
	assign next_flags = ((flags & ~clear_bits) | set_bits) & SUPPORTED;

	// flag storage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flags <= FLAG_RESET;
		else
			flags <= next_flags;
	end

endmodule

`default_nettype wire

// File: logic/psfb_status_bank.sv
// psfb_status_bank: latched status flag bytes of a two-channel
// controller, read and cleared one byte at a time by command code.
// assumes: protocol logic on clk delivers decoded byte accesses,
// holds the page selector, and raises comm events as pulses.
`timescale 1ns/1ps
`default_nettype none

module psfb_status_bank
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   cmd_valid,
	input  wire logic                   cmd_write,
	input  wire logic [7:0]             cmd_code,
	input  wire logic [7:0]             cmd_wdata,
	input  wire logic [7:0]             page_sel,
	input  wire logic                   input_overvoltage_fault,
	input  wire logic                   input_undervoltage_fault,
	input  wire logic                   low_input_shutdown,
	input  wire logic                   input_overcurrent_fault,
	input  wire logic                   input_overcurrent_warning,
	input  wire logic                   input_overpower_warning,
	input  wire logic                   overtemp_fault_a,
	input  wire logic                   overtemp_warning_a,
	input  wire logic                   overtemp_fault_b,
	input  wire logic                   overtemp_warning_b,
	input  wire logic [7:0]             vendor_cond_a,
	input  wire logic [7:0]             vendor_cond_b,
	input  wire logic                   bad_command_flag,
	input  wire logic                   bad_payload_flag,
	input  wire logic                   packet_check_error,
	input  wire logic                   nvm_error,
	input  wire logic                   other_link_fault,
	output var  logic                   rd_valid,
	output var  logic [7:0]             rd_data,
	output var  logic                   cmd_miss
);
	import psfb_pkg::*;

	// ************************************************************
	// access decode
	// ************************************************************
	wire logic          rd_req;     // read access this cycle
	wire logic          wr_req;     // write access this cycle
	wire logic          hit_in;     // input byte addressed
	wire logic          hit_temp;   // temperature byte addressed
	wire logic          hit_comm;   // comm byte addressed
	wire logic          hit_vend;   // vendor byte addressed
	wire logic          hit_any;    // any status byte addressed
	wire psfb_chan_type page_chan;  // channel picked by page

	// one byte per access, no block transfers
	assign rd_req   = cmd_valid & ~cmd_write;
	assign wr_req   = cmd_valid & cmd_write;
	assign hit_in   = (cmd_code == CMD_INPUT);
	assign hit_temp = (cmd_code == CMD_TEMP);
	assign hit_comm = (cmd_code == CMD_COMM);
	assign hit_vend = (cmd_code == CMD_VENDOR);
	assign hit_any  = hit_in | hit_temp | hit_comm | hit_vend;

	// page decode; unknown pages select nothing
	assign page_chan = (page_sel == PAGE_A)   ? PSFB_CHAN_A :
	                   (page_sel == PAGE_B)   ? PSFB_CHAN_B :
	                   (page_sel == PAGE_ALL) ? PSFB_CHAN_ALL :
	                                            PSFB_CHAN_NONE;

	// ************************************************************
	// shared bytes: input and comm/logic/memory
	// ************************************************************
	wire logic [7:0] in_set;    // input conditions in place
	wire logic [7:0] in_clr;    // input clear bits
	wire logic [7:0] in_flags;  // latched input byte
	wire logic [7:0] cm_set;    // comm events in place
	wire logic [7:0] cm_clr;    // comm clear bits
	wire logic [7:0] cm_flags;  // latched comm byte

	// input conditions land at their field positions
	assign in_set = {input_overvoltage_fault, 2'b00,
	                 input_undervoltage_fault, low_input_shutdown,
	                 input_overcurrent_fault, input_overcurrent_warning,
	                 input_overpower_warning};
	// page not looked at for the input byte
	assign in_clr = (wr_req & hit_in) ? cmd_wdata : 8'h00;

	// comm events at bits 7,6,5,3,1
	assign cm_set = {bad_command_flag, bad_payload_flag,
	                 packet_check_error, 1'b0,
	                 nvm_error, 1'b0,
	                 other_link_fault, 1'b0};
	// one byte for both channels
	assign cm_clr = (wr_req & hit_comm) ? cmd_wdata : 8'h00;

	// input byte, bits 6,5 held low
	psfb_flag_byte #(.SUPPORTED(INPUT_MASK)) u_input
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.set_bits   (in_set),
		.clear_bits (in_clr),
		.flags      (in_flags)
	);

	// comm byte, bits 4,2,0 held low
	psfb_flag_byte #(.SUPPORTED(COMM_MASK)) u_comm
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.set_bits   (cm_set),
		.clear_bits (cm_clr),
		.flags      (cm_flags)
	);

	// ************************************************************
	// paged bytes: temperature and vendor, one pair per channel
	// ************************************************************
	logic [7:0] tp_set   [0:1]; // temperature conditions
	logic [7:0] vd_set   [0:1]; // vendor conditions
	logic [7:0] tp_flags [0:1]; // latched temperature bytes
	logic [7:0] vd_flags [0:1]; // latched vendor bytes
	wire  logic [1:0] wr_chan;  // channels a write reaches

	assign tp_set[0] = {overtemp_fault_a, overtemp_warning_a, 6'h00};
	assign tp_set[1] = {overtemp_fault_b, overtemp_warning_b, 6'h00};
	assign vd_set[0] = vendor_cond_a;
	assign vd_set[1] = vendor_cond_b;
	assign wr_chan   = page_chan;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : g_chan
			wire logic [7:0] tp_clr; // temperature clear bits
			wire logic [7:0] vd_clr; // vendor clear bits

			// clear only on the paged channel
			assign tp_clr = (wr_req & hit_temp & wr_chan[ch]) ? cmd_wdata : 8'h00;
			assign vd_clr = (wr_req & hit_vend & wr_chan[ch]) ? cmd_wdata : 8'h00;

			// fault bit 7, warning bit 6, rest zero
			psfb_flag_byte #(.SUPPORTED(TEMP_MASK)) u_temp
			(
				.clk        (clk),
				.rst_n      (rst_n),
				.set_bits   (tp_set[ch]),
				.clear_bits (tp_clr),
				.flags      (tp_flags[ch])
			);

			// vendor byte per channel
			psfb_flag_byte #(.SUPPORTED(VEND_MASK)) u_vend
			(
				.clk        (clk),
				.rst_n      (rst_n),
				.set_bits   (vd_set[ch]),
				.clear_bits (vd_clr),
				.flags      (vd_flags[ch])
			);
		end
	endgenerate

	// ************************************************************
	// read selection
	// ************************************************************
	wire logic       rd_b;       // paged read goes to channel b
	wire logic       rd_a;       // paged read goes to channel a
	wire logic [7:0] tp_rd;      // paged temperature answer
	wire logic [7:0] vd_rd;      // paged vendor answer
	wire logic [7:0] next_rd;    // selected answer

	assign rd_b  = (page_chan == PSFB_CHAN_B);
	assign rd_a  = (page_chan == PSFB_CHAN_A) |
	               (page_chan == PSFB_CHAN_ALL);
	assign tp_rd = rd_b ? tp_flags[1] : rd_a ? tp_flags[0] : READ_NONE;
	assign vd_rd = rd_b ? vd_flags[1] : rd_a ? vd_flags[0] : READ_NONE;
	assign next_rd = hit_in   ? in_flags :
	                 hit_comm ? cm_flags :
	                 hit_temp ? tp_rd :
	                 hit_vend ? vd_rd : READ_NONE;

	// answer register, held until the next read
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_valid <= 1'b0;
			rd_data  <= READ_NONE;
			cmd_miss <= 1'b0;
		end
		else
		begin
			rd_valid <= rd_req;
			if (rd_req)
				rd_data <= next_rd;
			cmd_miss <= cmd_valid & ~hit_any;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd(logic [7:0] code);
		rd_req && cmd_code == code;
	endsequence
	sequence s_wr_in_ovf;
		wr_req && hit_in && cmd_wdata[IN_OVF_BIT];
	endsequence

	a_input_latch_ovf: assert property
		(input_overvoltage_fault |=> in_flags[IN_OVF_BIT])
		else $error("input overvoltage not latched");
	a_unused_read_zero: assert property
		(s_rd(CMD_INPUT) |=> rd_valid && rd_data[6:5] == 2'b00)
		else $error("unused input bits read nonzero");
	a_clear_by_one: assert property
		(s_wr_in_ovf ##0 !input_overvoltage_fault |=> !in_flags[IN_OVF_BIT])
		else $error("write one did not clear flag");
	a_page_b_read: assert property
		(s_rd(CMD_TEMP) ##0 page_sel == PAGE_B |=> rd_data == $past(tp_flags[1]))
		else $error("page b read wrong channel");
	a_page_all_read: assert property
		(s_rd(CMD_VENDOR) ##0 page_sel == PAGE_ALL |=> rd_data == $past(vd_flags[0]))
		else $error("page ff read not channel a");
	a_comm_shared: assert property
		(s_rd(CMD_COMM) |=> rd_data == $past(cm_flags))
		else $error("comm read depends on page");
	a_temp_reserved: assert property
		(s_rd(CMD_TEMP) |=> rd_data[5:0] == 6'h00)
		else $error("temperature low bits nonzero");
	a_bad_cmd_set: assert property
		(bad_command_flag |=> cm_flags[CM_CMD_BIT])
		else $error("bad command not latched");
	a_bad_data_set: assert property
		(bad_payload_flag |=> cm_flags[CM_DATA_BIT])
		else $error("bad payload not latched");
	a_check_error_set: assert property
		(packet_check_error |=> cm_flags[CM_PEC_BIT])
		else $error("packet check error not latched");
	a_mem_err_set: assert property
		(nvm_error |=> cm_flags[CM_MEM_BIT])
		else $error("memory error not latched");
	a_other_fault_set: assert property
		(other_link_fault |=> cm_flags[CM_OTH_BIT])
		else $error("other link fault not latched");
	a_vendor_page_a: assert property
		(s_rd(CMD_VENDOR) ##0 page_sel == PAGE_A |=> rd_data == $past(vd_flags[0]))
		else $error("vendor page a read wrong");
	a_input_page_free: assert property
		(s_wr_in_ovf ##0 page_sel == PAGE_B && !input_overvoltage_fault
			|=> !in_flags[IN_OVF_BIT])
		else $error("input clear depends on page");
	a_flag_holds: assert property
		(in_flags[IN_LOW_BIT] && !in_clr[IN_LOW_BIT] |=> in_flags[IN_LOW_BIT] [*1])
		else $error("latched flag dropped without clear");
	a_set_beats_clear: assert property
		(s_wr_in_ovf ##0 input_overvoltage_fault |=> in_flags[IN_OVF_BIT])
		else $error("present condition lost on clear");

endmodule

`default_nettype wire

// File: tb/psfb_host_model.sv
// psfb_host_model: host side issuing single byte status accesses.
// assumes: one clock; the bench calls access() for every transfer.
`timescale 1ns/1ps
`default_nettype none

module psfb_host_model
(
	input  wire logic       clk,       // device clock
	output var  logic       cmd_valid, // access strobe
	output var  logic       cmd_write, // 1 write, 0 read
	output var  logic [7:0] cmd_code,  // command code
	output var  logic [7:0] cmd_wdata, // clear mask
	output var  logic [7:0] page_sel,  // channel selector
	input  wire logic       rd_valid,  // read answer strobe
	input  wire logic [7:0] rd_data,   // read answer
	input  wire logic       cmd_miss   // unmapped code strobe
);
	// ************************************************************
	// idle levels at time zero
	// ************************************************************
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 8'h00;
		page_sel  = 8'h00;
	end

	// ************************************************************
	// one byte access, answer taken one cycle after the strobe
	// ************************************************************
	task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] data,
		input logic [7:0] page, output logic [7:0] rdat, output logic vld, output logic miss);
		@(posedge clk);
		cmd_valid <= 1'b1; // single byte only
		cmd_write <= wr;
		cmd_code  <= code;
		cmd_wdata <= data; // ones pick flags to clear
		page_sel  <= page; // channel choice
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code  <= ~code; // released lines never show the old value
		cmd_wdata <= ~data;
		#1;
		rdat = rd_data;
		vld  = rd_valid;
		miss = cmd_miss;
	endtask
endmodule

`default_nettype wire

// File: tb/psfb_status_bank_bench.sv
// psfb_status_bank_bench: random and corner checks of the flag bank.
// assumes: psfb_pkg compiled first, host model beside the design.
`timescale 1ns/1ps
`default_nettype none

module psfb_status_bank_bench;
	import psfb_pkg::*;
	logic       clk, rst_n;                 // clock and reset
	logic       cmd_valid, cmd_write;       // host strobe and kind
	logic [7:0] cmd_code, cmd_wdata, page_sel; // host fields
	logic       rd_valid, cmd_miss;         // design strobes
	logic [7:0] rd_data;                    // read answer
	logic [7:0] in_c, cm_c, va, vb;         // condition drives
	logic [1:0] t_a, t_b;                   // temp conditions
	logic [7:0] exp_in, exp_cm, exp_ta, exp_tb, exp_va, exp_vb; // expected flags
	logic [7:0] r_in, r_cm, r_va, r_vb;     // random draws
	logic [1:0] r_ta, r_tb;                 // random temp draws
	logic [7:0] last_rd;                    // answer of the last read
	int         bad_count, tests_run, i, seed; // counters and seed
	logic [7:0] codes [5] = '{CMD_INPUT, CMD_TEMP, CMD_COMM, CMD_VENDOR, 8'h55};
	logic [7:0] pages [4] = '{PAGE_A, PAGE_B, PAGE_ALL, 8'h02};

	// ************************************************************
	// design and host
	// ************************************************************
	psfb_status_bank uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.page_sel(page_sel), .input_overvoltage_fault(in_c[7]),
		.input_undervoltage_fault(in_c[4]), .low_input_shutdown(in_c[3]),
		.input_overcurrent_fault(in_c[2]), .input_overcurrent_warning(in_c[1]),
		.input_overpower_warning(in_c[0]), .overtemp_fault_a(t_a[1]),
		.overtemp_warning_a(t_a[0]), .overtemp_fault_b(t_b[1]),
		.overtemp_warning_b(t_b[0]), .vendor_cond_a(va), .vendor_cond_b(vb),
		.bad_command_flag(cm_c[7]), .bad_payload_flag(cm_c[6]),
		.packet_check_error(cm_c[5]), .nvm_error(cm_c[3]),
		.other_link_fault(cm_c[1]), .rd_valid(rd_valid), .rd_data(rd_data),
		.cmd_miss(cmd_miss));
	psfb_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .page_sel(page_sel),
		.rd_valid(rd_valid), .rd_data(rd_data), .cmd_miss(cmd_miss));

	// ************************************************************
	// clock, watchdog and verdict
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// cut a hang short: about twenty times the expected run
	initial
	begin
		#200000;
		bad_count++;
		report_and_stop();
	end

	task automatic report_and_stop();
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ************************************************************
	// compares and expectations
	// ************************************************************
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_byte({7'h00, got}, {7'h00, exp});
	endtask

	// paged pick: 00 and ff give channel a, 01 channel b, else none
	function automatic logic [7:0] pick(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] page);
		pick = (page == PAGE_A || page == PAGE_ALL) ? a : (page == PAGE_B) ? b : READ_NONE;
	endfunction

	function automatic logic [7:0] expect_read(input logic [7:0] code, input logic [7:0] page);
		case (code)
			CMD_INPUT:  expect_read = exp_in; // shared
			CMD_TEMP:   expect_read = pick(exp_ta, exp_tb, page);
			CMD_COMM:   expect_read = exp_cm; // shared
			CMD_VENDOR: expect_read = pick(exp_va, exp_vb, page);
			default:    expect_read = READ_NONE;
		endcase
	endfunction

	// one access with its checks and the expected-flag update
	task automatic run(input logic wr, input logic [7:0] code, input logic [7:0] wd,
		input logic [7:0] page);
		logic [7:0] got;
		logic       vld, miss, known, la, lb;
		known = code == CMD_INPUT || code == CMD_TEMP || code == CMD_COMM || code == CMD_VENDOR;
		la = page == PAGE_A || page == PAGE_ALL;
		lb = page == PAGE_B || page == PAGE_ALL;
		host.access(wr, code, wd, page, got, vld, miss);
		check_bit(vld, !wr);
		check_bit(miss, !known); // unmapped code strobe
		if (!wr)
		begin
			last_rd = expect_read(code, page);
			check_byte(got, last_rd);
		end
		else
		begin
			check_byte(got, last_rd); // answer stands over a write
			exp_in &= (code == CMD_INPUT) ? ~wd : 8'hff;
			exp_cm &= (code == CMD_COMM) ? ~wd : 8'hff;
			exp_ta &= (code == CMD_TEMP && la) ? ~wd : 8'hff;
			exp_tb &= (code == CMD_TEMP && lb) ? ~wd : 8'hff;
			exp_va &= (code == CMD_VENDOR && la) ? ~wd : 8'hff;
			exp_vb &= (code == CMD_VENDOR && lb) ? ~wd : 8'hff;
		end
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		rst_n = 1'b0;
		{in_c, cm_c, va, vb, t_a, t_b} = '0;
		{exp_in, exp_cm, exp_ta, exp_tb, exp_va, exp_vb} = '0;
		last_rd = READ_NONE;
		bad_count = 0;
		tests_run = 0;
		seed = 32'h026ed05f;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// input, comm and channel b temperature bytes read empty after reset
		for (i = 0; i < 5; i++)
			run(1'b0, codes[i], 8'h00, pages[i % 4]);
		// random condition pulses, then a random access
		for (i = 0; i < 300; i++)
		begin
			r_in = 8'($random(seed) & $random(seed));
			r_cm = 8'($random(seed) & $random(seed));
			r_va = 8'($random(seed) & $random(seed));
			r_vb = 8'($random(seed) & $random(seed));
			r_ta = 2'($random(seed) & $random(seed));
			r_tb = 2'($random(seed) & $random(seed));
			@(posedge clk);
			{in_c, cm_c, va, vb, t_a, t_b} <= {r_in, r_cm, r_va, r_vb, r_ta, r_tb};
			@(posedge clk);
			{in_c, cm_c, va, vb, t_a, t_b} <= '0;
			exp_in |= r_in & INPUT_MASK;
			exp_cm |= r_cm & COMM_MASK;
			exp_ta |= {r_ta, 6'h00};
			exp_tb |= {r_tb, 6'h00};
			exp_va |= r_va & VEND_MASK;
			exp_vb |= r_vb & VEND_MASK;
			run(1'($random(seed)), codes[{$random(seed)} % 5], 8'($random(seed)),
				pages[{$random(seed)} % 4]);
		end
		// clear while the condition is still present keeps the flag
		@(posedge clk);
		in_c <= 8'h80;
		run(1'b1, CMD_INPUT, 8'hff, PAGE_B);
		in_c <= 8'h00;
		exp_in = 8'h80;
		run(1'b0, CMD_INPUT, 8'h00, PAGE_ALL);
		report_and_stop();
	end
endmodule

`default_nettype wire
